// file: common/ssx_pkg.sv
package ssx_pkg;

  // ***************************************************************
  // operation codes presented by the decode stage
  // ***************************************************************
  typedef enum logic [4:0] {
    SSX_OP_NONE,
    SSX_OP_SET_BIT,
    SSX_OP_INC_SKIP_ZERO,
    SSX_OP_INC_COPY_SKIP_ZERO,
    SSX_OP_SKIP_NONZERO_BIT,
    SSX_OP_SKIP_NONZERO,
    SSX_OP_SKIP_ZERO_MEM,
    SSX_OP_COPY_SKIP_ZERO,
    SSX_OP_SKIP_ZERO_BIT,
    SSX_OP_SUB_MEM,
    SSX_OP_MINUS_TO_MEMORY,
    SSX_OP_SUB_IMM,
    SSX_OP_SWAP,
    SSX_OP_NIBBLE_EXCHANGE_TO_WORKING,
    SSX_OP_TABLE_READ_PAGED,
    SSX_OP_TABLE_READ_LAST_PAGE,
    SSX_OP_PREINC_TABLE_READ_PAGED,
    SSX_OP_PREINC_TABLE_READ_LAST,
    SSX_OP_XOR_MEM,
    SSX_OP_BITWISE_DIFFER_TO_MEMORY,
    SSX_OP_XOR_IMM
  } ssx_op_t;

  typedef enum {
    SSX_ST_IDLE,
    SSX_ST_TABLE,
    SSX_ST_DUMMY
  } ssx_state_t;

  // ***************************************************************
  // widths and reset values
  // ***************************************************************
  localparam int            SSX_DATA_W     = 8;
  localparam int            SSX_BIT_SEL_W  = 3;
  localparam int            SSX_NIB_W      = 4;
  localparam logic [7:0]    SSX_BYTE_ZERO  = 8'h00;
  localparam logic [7:0]    SSX_BYTE_ONE   = 8'h01;
  localparam logic [7:0]    SSX_LAST_PAGE  = 8'hFF;
  localparam logic [15:0]   SSX_WORD_ZERO  = 16'h0000;

endpackage

// file: rtl/ssx_exec.sv
`timescale 1ns/100ps

// Overview of operation
// - set bit forces one, flags untouched
// - increment memory, write back, skip if zero
// - skipping inserts a dummy cycle
// - increment copy to working, skip if zero
// - bit skip when selected bit is one
// - byte rewrite, skip when nonzero
// - byte rewrite, skip when zero
// - copy to working, skip when zero
// - bit skip when selected bit is zero
// - working minus memory into working
// - carry means no borrow
// - subtraction updates all six flags
// - working minus memory into memory
// - working minus immediate into working
// - swap memory nibbles in place
// - swapped nibbles into working register
// - paged table read via both pointers
// - last page table read via low pointer
// - preincrement low pointer then paged read
// - preincrement low pointer then last page read
// - xor memory into working, zero only
// - xor into memory, zero only
// - xor immediate into working, zero only
module ssx_exec
  import ssx_pkg::*;
#(
  parameter int DATA_W = SSX_DATA_W,
  parameter int ADDR_W = 8
)(
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  input  wire logic                op_valid,
  input  ssx_op_t                  op_code,
  input  wire logic [ADDR_W-1:0]   op_addr,
  input  wire logic [2:0]          op_bit,
  input  wire logic [DATA_W-1:0]   op_imm,
  input  wire logic [DATA_W-1:0]   mem_rdata,
  input  wire logic [15:0]         prog_rdata,
  input  wire logic                prog_rvalid,
  input  wire logic                table_pointer_low_wr,
  input  wire logic                table_pointer_high_wr,
  input  wire logic [DATA_W-1:0]   table_pointer_wdata,
  output logic                     busy,
  output logic                     skip_dummy,
  output logic                     mem_we,
  output logic [ADDR_W-1:0]        mem_waddr,
  output logic [DATA_W-1:0]        mem_wdata,
  output logic                     prog_req,
  output logic [15:0]              prog_addr,
  output logic [DATA_W-1:0]        working_register,
  output logic [DATA_W-1:0]        table_pointer_low,
  output logic [DATA_W-1:0]        table_pointer_high,
  output logic [DATA_W-1:0]        table_high_byte_latch,
  output logic                     carry_flag,
  output logic                     zero_flag,
  output logic                     half_carry_flag,
  output logic                     signed_wrap_flag,
  output logic                     signed_carry_flag,
  output logic                     chained_zero_flag
);

  // ***************************************************************
  // arithmetic helpers
  // ***************************************************************
  function automatic logic [DATA_W:0] sub_ext(input logic [DATA_W-1:0] a,
                                              input logic [DATA_W-1:0] b);
    sub_ext = {1'b0, a} - {1'b0, b};
  endfunction

  function automatic logic [DATA_W-1:0] swap_nib(input logic [DATA_W-1:0] v);
    swap_nib = {v[SSX_NIB_W-1:0], v[DATA_W-1:SSX_NIB_W]};
  endfunction

  ssx_state_t                state;
  logic                      take;
  logic [DATA_W-1:0]         inc_val;
  logic [DATA_W-1:0]         sub_b;
  logic [DATA_W:0]           sub_wide;
  logic [SSX_NIB_W:0]        sub_low;
  logic [DATA_W-1:0]         sub_res;
  logic                      sub_ov;
  logic [DATA_W-1:0]         xor_b;
  logic [DATA_W-1:0]         xor_res;
  logic                      do_skip;
  logic                      is_sub;
  logic                      is_xor;
  logic                      is_tbl;
  logic                      is_preinc;
  logic                      is_last;
  logic [DATA_W-1:0]         next_tplo;
  logic [ADDR_W-1:0]         tbl_addr;

  assign take     = op_valid && (state == SSX_ST_IDLE);
  assign inc_val  = mem_rdata + SSX_BYTE_ONE;
  assign is_sub   = op_code inside {SSX_OP_SUB_MEM, SSX_OP_MINUS_TO_MEMORY, SSX_OP_SUB_IMM};
  assign sub_b    = (op_code == SSX_OP_SUB_IMM) ? op_imm : mem_rdata;
  assign sub_wide = sub_ext(working_register, sub_b);
  assign sub_low  = {1'b0, working_register[SSX_NIB_W-1:0]} - {1'b0, sub_b[SSX_NIB_W-1:0]};
  assign sub_res  = sub_wide[DATA_W-1:0];
  assign sub_ov   = (working_register[DATA_W-1] != sub_b[DATA_W-1])
                    && (sub_res[DATA_W-1] != working_register[DATA_W-1]);
  assign is_xor   = op_code inside {SSX_OP_XOR_MEM, SSX_OP_BITWISE_DIFFER_TO_MEMORY,
                                    SSX_OP_XOR_IMM};
  assign xor_b    = (op_code == SSX_OP_XOR_IMM) ? op_imm : mem_rdata;
  assign xor_res  = working_register ^ xor_b;
  assign is_tbl   = op_code inside {SSX_OP_TABLE_READ_PAGED, SSX_OP_TABLE_READ_LAST_PAGE,
                                    SSX_OP_PREINC_TABLE_READ_PAGED,
                                    SSX_OP_PREINC_TABLE_READ_LAST};
  assign is_preinc = op_code inside {SSX_OP_PREINC_TABLE_READ_PAGED,
                                     SSX_OP_PREINC_TABLE_READ_LAST};
  assign is_last  = op_code inside {SSX_OP_TABLE_READ_LAST_PAGE,
                                    SSX_OP_PREINC_TABLE_READ_LAST};
  assign next_tplo = is_preinc ? table_pointer_low + SSX_BYTE_ONE : table_pointer_low;

  // ***************************************************************
  // skip decision
  // ***************************************************************
  always_comb
  begin
    unique case (op_code)
      SSX_OP_INC_SKIP_ZERO:      do_skip = (inc_val == SSX_BYTE_ZERO);
      SSX_OP_INC_COPY_SKIP_ZERO: do_skip = (inc_val == SSX_BYTE_ZERO);
      SSX_OP_SKIP_NONZERO_BIT:   do_skip = mem_rdata[op_bit];
      SSX_OP_SKIP_NONZERO:       do_skip = (mem_rdata != SSX_BYTE_ZERO);
      SSX_OP_SKIP_ZERO_MEM:      do_skip = (mem_rdata == SSX_BYTE_ZERO);
      SSX_OP_COPY_SKIP_ZERO:     do_skip = (mem_rdata == SSX_BYTE_ZERO);
      SSX_OP_SKIP_ZERO_BIT:      do_skip = !mem_rdata[op_bit];
      default:                   do_skip = 1'b0;
    endcase
  end

  // ***************************************************************
  // sequencing
  // ***************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      state <= SSX_ST_IDLE;
    else
      unique case (state)
        SSX_ST_IDLE:
          if (take && is_tbl)
            state <= SSX_ST_TABLE;
          else if (take && do_skip)
            state <= SSX_ST_DUMMY;
        SSX_ST_TABLE:
          if (prog_rvalid)
            state <= SSX_ST_IDLE;
        SSX_ST_DUMMY:
          state <= SSX_ST_IDLE;
      endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      busy       <= 1'b0;
      skip_dummy <= 1'b0;
    end
    else
    begin
      busy       <= (take && (is_tbl || do_skip)) || (state == SSX_ST_TABLE && !prog_rvalid);
      skip_dummy <= take && do_skip && !is_tbl;
    end
  end

  // ***************************************************************
  // table pointers and program read
  // ***************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      table_pointer_low  <= SSX_BYTE_ZERO;
      table_pointer_high <= SSX_BYTE_ZERO;
      prog_req           <= 1'b0;
      prog_addr          <= SSX_WORD_ZERO;
      tbl_addr           <= '0;
    end
    else
    begin
      prog_req <= take && is_tbl;
      if (take && is_tbl)
      begin
        table_pointer_low <= next_tplo;
        tbl_addr          <= op_addr;
        if (is_last)
          prog_addr <= {SSX_LAST_PAGE, next_tplo};
        else
          prog_addr <= {table_pointer_high, next_tplo};
      end
      else if (table_pointer_low_wr)
        table_pointer_low <= table_pointer_wdata;
      if (table_pointer_high_wr)
        table_pointer_high <= table_pointer_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      table_high_byte_latch <= SSX_BYTE_ZERO;
    else if (state == SSX_ST_TABLE && prog_rvalid)
      table_high_byte_latch <= prog_rdata[15:8];
  end

  // ***************************************************************
  // data memory write port
  // ***************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      mem_we    <= 1'b0;
      mem_waddr <= '0;
      mem_wdata <= SSX_BYTE_ZERO;
    end
    else if (state == SSX_ST_TABLE)
    begin
      mem_we    <= prog_rvalid;
      mem_waddr <= tbl_addr;
      mem_wdata <= prog_rdata[7:0];
    end
    else
    begin
      mem_we    <= take && (op_code inside {SSX_OP_SET_BIT, SSX_OP_INC_SKIP_ZERO,
                                            SSX_OP_SKIP_NONZERO, SSX_OP_SKIP_ZERO_MEM,
                                            SSX_OP_MINUS_TO_MEMORY, SSX_OP_SWAP,
                                            SSX_OP_BITWISE_DIFFER_TO_MEMORY});
      mem_waddr <= op_addr;
      if (take)
        unique case (op_code)
          SSX_OP_SET_BIT:
            mem_wdata <= mem_rdata | (SSX_BYTE_ONE << op_bit);
          SSX_OP_INC_SKIP_ZERO:
            mem_wdata <= inc_val;
          SSX_OP_SKIP_NONZERO, SSX_OP_SKIP_ZERO_MEM:
            mem_wdata <= mem_rdata;
          SSX_OP_MINUS_TO_MEMORY:
            mem_wdata <= sub_res;
          SSX_OP_SWAP:
            mem_wdata <= swap_nib(mem_rdata);
          SSX_OP_BITWISE_DIFFER_TO_MEMORY:
            mem_wdata <= xor_res;
          default:
            mem_wdata <= mem_wdata;
        endcase
    end
  end

  // ***************************************************************
  // working register
  // ***************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      working_register <= SSX_BYTE_ZERO;
    else if (take)
      unique case (op_code)
        SSX_OP_INC_COPY_SKIP_ZERO:   working_register <= inc_val;
        SSX_OP_COPY_SKIP_ZERO:       working_register <= mem_rdata;
        SSX_OP_SUB_MEM:              working_register <= sub_res;
        SSX_OP_SUB_IMM:              working_register <= sub_res;
        SSX_OP_NIBBLE_EXCHANGE_TO_WORKING:
          working_register <= swap_nib(mem_rdata);
        SSX_OP_XOR_MEM:              working_register <= xor_res;
        SSX_OP_XOR_IMM:              working_register <= xor_res;
        default:                     working_register <= working_register;
      endcase
  end

  // ***************************************************************
  // status flags
  // ***************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      carry_flag        <= 1'b0;
      zero_flag         <= 1'b0;
      half_carry_flag   <= 1'b0;
      signed_wrap_flag  <= 1'b0;
      signed_carry_flag <= 1'b0;
      chained_zero_flag <= 1'b0;
    end
    else if (take && is_sub)
    begin
      carry_flag        <= !sub_wide[DATA_W];
      half_carry_flag   <= !sub_low[SSX_NIB_W];
      signed_wrap_flag  <= sub_ov;
      zero_flag         <= (sub_res == SSX_BYTE_ZERO);
      signed_carry_flag <= sub_ov ^ sub_res[DATA_W-1];
      chained_zero_flag <= (sub_res == SSX_BYTE_ZERO);
    end
    else if (take && is_xor)
      zero_flag <= (xor_res == SSX_BYTE_ZERO);
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  property p_skip_dummy;
    @(posedge ref_clk) disable iff (!rstn)
    (take && do_skip && !is_tbl) |=> skip_dummy && busy ##1 !skip_dummy;
  endproperty
  a_skip_dummy: assert property (p_skip_dummy) else $error("skip without dummy");

  property p_inc_skip;
    @(posedge ref_clk) disable iff (!rstn)
    (take && op_code == SSX_OP_INC_SKIP_ZERO) |=> mem_we && (mem_wdata == $past(inc_val))
      && (skip_dummy == (mem_wdata == SSX_BYTE_ZERO));
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("increment skip wrong");

  property p_inc_copy;
    @(posedge ref_clk) disable iff (!rstn)
    (take && op_code == SSX_OP_INC_COPY_SKIP_ZERO) |=> !mem_we
      && (skip_dummy == (working_register == SSX_BYTE_ZERO));
  endproperty
  a_inc_copy: assert property (p_inc_copy) else $error("increment copy wrong");

  property p_bit_skip;
    @(posedge ref_clk) disable iff (!rstn)
    (take && op_code == SSX_OP_SKIP_ZERO_BIT) |=> skip_dummy != $past(mem_rdata[op_bit]);
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit zero skip wrong");

  property p_sub_carry;
    @(posedge ref_clk) disable iff (!rstn)
    (take && op_code == SSX_OP_SUB_MEM) |=>
      carry_flag == ($past(working_register) >= $past(mem_rdata));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("borrow flag wrong");
  property p_sub_mem;
    @(posedge ref_clk) disable iff (!rstn)
    (take && op_code == SSX_OP_MINUS_TO_MEMORY) |=> mem_we && $stable(working_register)
      && zero_flag == (mem_wdata == SSX_BYTE_ZERO);
  endproperty
  a_sub_mem: assert property (p_sub_mem) else $error("subtract to memory wrong");
  property p_xor_flags;
    @(posedge ref_clk) disable iff (!rstn)
    (take && op_code == SSX_OP_XOR_IMM) |=> $stable(carry_flag) && $stable(half_carry_flag)
      && zero_flag == (working_register == SSX_BYTE_ZERO);
  endproperty
  a_xor_flags: assert property (p_xor_flags) else $error("xor flags wrong");
  property p_table_latch;
    @(posedge ref_clk) disable iff (!rstn)
    (state == SSX_ST_TABLE && prog_rvalid) |=> mem_we
      && table_high_byte_latch == $past(prog_rdata[15:8]);
  endproperty
  a_table_latch: assert property (p_table_latch) else $error("table read wrong");
  property p_last_page;
    @(posedge ref_clk) disable iff (!rstn)
    (take && op_code == SSX_OP_PREINC_TABLE_READ_LAST) |=> prog_req
      && table_pointer_low == $past(table_pointer_low) + SSX_BYTE_ONE
      && prog_addr == {SSX_LAST_PAGE, table_pointer_low};
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page address wrong");

endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  import ssx_pkg::*;

  // ***************************************************************
  // stimulus and observed signals
  // ***************************************************************
  logic        ref_clk;
  logic        rstn;
  logic        op_valid;
  ssx_op_t     op_code;
  logic [7:0]  op_addr;
  logic [2:0]  op_bit;
  logic [7:0]  op_imm;
  logic [7:0]  mem_rdata;
  logic [15:0] prog_rdata;
  logic        prog_rvalid;
  logic        tpl_wr;
  logic        tph_wr;
  logic [7:0]  tp_wdata;
  logic        busy;
  logic        skip_dummy;
  logic        mem_we;
  logic [7:0]  mem_waddr;
  logic [7:0]  mem_wdata;
  logic        prog_req;
  logic [15:0] prog_addr;
  logic [7:0]  wreg;
  logic [7:0]  tpl;
  logic [7:0]  tph;
  logic [7:0]  latch;
  logic        c_f;
  logic        z_f;
  logic        hc_f;
  logic        wrap_f;
  logic        scar_f;
  logic        chz_f;
  wire  [5:0]  flags_seen = {c_f, z_f, hc_f, wrap_f, scar_f, chz_f};

  // model state, flags ordered carry zero half wrap signed chained
  logic [7:0]  m_wreg;
  logic [7:0]  m_tpl;
  logic [7:0]  m_tph;
  logic [7:0]  m_latch;
  logic [5:0]  m_flg;
  logic        e_we;
  logic [7:0]  e_wd;
  logic        e_skip;
  logic [31:0] seed;
  logic [31:0] r32;
  int          mismatches;
  int          compares;
  int          cycles;

  ssx_exec dut (
    .ref_clk(ref_clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_bit(op_bit), .op_imm(op_imm), .mem_rdata(mem_rdata),
    .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid),
    .table_pointer_low_wr(tpl_wr), .table_pointer_high_wr(tph_wr),
    .table_pointer_wdata(tp_wdata), .busy(busy), .skip_dummy(skip_dummy),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
    .prog_req(prog_req), .prog_addr(prog_addr), .working_register(wreg),
    .table_pointer_low(tpl), .table_pointer_high(tph),
    .table_high_byte_latch(latch), .carry_flag(c_f), .zero_flag(z_f),
    .half_carry_flag(hc_f), .signed_wrap_flag(wrap_f),
    .signed_carry_flag(scar_f), .chained_zero_flag(chz_f)
  );

  // ***************************************************************
  // expectation functions
  // ***************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] do_sub(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = a - b;
    m_flg[5] = (a >= b);
    m_flg[4] = (r == 8'h00);
    m_flg[3] = (a[3:0] >= b[3:0]);
    m_flg[2] = (a[7] != b[7]) && (r[7] != a[7]);
    m_flg[1] = m_flg[2] ^ r[7];
    m_flg[0] = (r == 8'h00);
    return r;
  endfunction

  function automatic logic [7:0] xz(input logic [7:0] v);
    m_flg[4] = (v == 8'h00);
    return v;
  endfunction

  function automatic void put(input logic we, input logic [7:0] wd, input logic sk);
    e_we = we;
    e_wd = wd;
    e_skip = sk;
  endfunction

  function automatic void to_wreg(input logic [7:0] v, input logic sk);
    m_wreg = v;
    e_skip = sk;
  endfunction

  function automatic void predict(input ssx_op_t op, input logic [7:0] m);
    logic [7:0] r;
    r = m + 8'h01;
    put(1'b0, m, 1'b0);
    case (op)
      SSX_OP_SET_BIT:                    put(1'b1, m | (8'h01 << op_bit), 1'b0);
      SSX_OP_INC_SKIP_ZERO:              put(1'b1, r, r == 8'h00);
      SSX_OP_INC_COPY_SKIP_ZERO:         to_wreg(r, r == 8'h00);
      SSX_OP_SKIP_NONZERO_BIT:           put(1'b0, m, m[op_bit]);
      SSX_OP_SKIP_NONZERO:               put(1'b1, m, m != 8'h00);
      SSX_OP_SKIP_ZERO_MEM:              put(1'b1, m, m == 8'h00);
      SSX_OP_COPY_SKIP_ZERO:             to_wreg(m, m == 8'h00);
      SSX_OP_SKIP_ZERO_BIT:              put(1'b0, m, !m[op_bit]);
      SSX_OP_SUB_MEM:                    to_wreg(do_sub(m_wreg, m), 1'b0);
      SSX_OP_MINUS_TO_MEMORY:            put(1'b1, do_sub(m_wreg, m), 1'b0);
      SSX_OP_SUB_IMM:                    to_wreg(do_sub(m_wreg, op_imm), 1'b0);
      SSX_OP_SWAP:                       put(1'b1, {m[3:0], m[7:4]}, 1'b0);
      SSX_OP_NIBBLE_EXCHANGE_TO_WORKING: to_wreg({m[3:0], m[7:4]}, 1'b0);
      SSX_OP_XOR_MEM:                    to_wreg(xz(m_wreg ^ m), 1'b0);
      SSX_OP_BITWISE_DIFFER_TO_MEMORY:   put(1'b1, xz(m_wreg ^ m), 1'b0);
      SSX_OP_XOR_IMM:                    to_wreg(xz(m_wreg ^ op_imm), 1'b0);
      default:                           put(1'b0, m, 1'b0);
    endcase
  endfunction

  // ***************************************************************
  // driver and check tasks
  // ***************************************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cyc();
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    op_valid = 1'b0;
    repeat (10) @(negedge ref_clk);
    m_wreg = 8'h00;
    m_flg = 6'h00;
    m_tpl = 8'h00;
    m_tph = 8'h00;
    m_latch = 8'h00;
    chk("reset ctl", 16'h0000, {busy, skip_dummy, mem_we, prog_req, flags_seen, 6'h00});
    chk("reset wreg latch", 16'h0000, {wreg, latch});
    chk("reset pointers", 16'h0000, {tph, tpl});
    rstn = 1'b1;
  endtask

  task automatic wr_ptr(input logic hi, input logic [7:0] v);
    op_valid = 1'b0;
    tp_wdata = v;
    tpl_wr = !hi;
    tph_wr = hi;
    cyc();
    tpl_wr = 1'b0;
    tph_wr = 1'b0;
    if (hi)
      m_tph = v;
    else
      m_tpl = v;
    chk("pointers", {m_tph, m_tpl}, {tph, tpl});
  endtask

  task automatic table_tail(input ssx_op_t op);
    logic [15:0] w;
    int          k;
    w = 16'(rnd());
    k = rnd() % 3;
    if (op == SSX_OP_PREINC_TABLE_READ_PAGED || op == SSX_OP_PREINC_TABLE_READ_LAST)
      m_tpl = m_tpl + 8'h01;
    chk("prog_req busy", 16'h0003, {prog_req, busy});
    chk("prog_addr", {(op == SSX_OP_TABLE_READ_PAGED || op == SSX_OP_PREINC_TABLE_READ_PAGED)
        ? m_tph : SSX_LAST_PAGE, m_tpl}, prog_addr);
    chk("early mem_we", 16'h0000, mem_we);
    // op still offered while the read is pending must be ignored
    repeat (k)
    begin
      cyc();
      chk("stall busy", 16'h0001, {prog_req, busy});
    end
    op_valid = 1'b0;
    prog_rvalid = 1'b1;
    prog_rdata = w;
    cyc();
    prog_rvalid = 1'b0;
    m_latch = w[15:8];
    chk("table write", {7'h01, op_addr}, {mem_we, mem_waddr});
    chk("table low byte", w[7:0], mem_wdata);
    chk("table latch", {m_latch, m_tpl}, {latch, tpl});
    chk("table done busy", 16'h0000, busy);
  endtask

  task automatic run_op(input ssx_op_t op);
    op_valid = 1'b1;
    op_code = op;
    predict(op, mem_rdata);
    cyc();
    if (op >= SSX_OP_TABLE_READ_PAGED && op <= SSX_OP_PREINC_TABLE_READ_LAST)
      table_tail(op);
    else
    begin
      chk("skip_dummy busy", {e_skip, e_skip}, {skip_dummy, busy});
      chk("mem_we", e_we, mem_we);
      if (e_we)
        chk("mem write", {op_addr, e_wd}, {mem_waddr, mem_wdata});
      chk("working_register", m_wreg, wreg);
      chk("flags", m_flg, flags_seen);
      if (e_skip)
      begin
        // op held through the dummy cycle must not be taken again
        cyc();
        chk("dummy end", 16'h0000, {skip_dummy, busy, mem_we});
      end
    end
  endtask

  // ***************************************************************
  // clock, timeout and main sequence
  // ***************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  initial
  begin
    seed = 32'h0000_0004;
    {op_valid, prog_rvalid, tpl_wr, tph_wr} = 4'h0;
    op_code = SSX_OP_NONE;
    {op_addr, op_bit, op_imm, mem_rdata, tp_wdata} = 35'h0;
    prog_rdata = 16'h0000;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    do_reset();
    wr_ptr(1'b1, 8'h5A);
    wr_ptr(1'b0, 8'hFF);
    for (int rd = 0; rd < 40; rd++)
    begin
      if (rd == 20)
        do_reset();
      for (int k = 1; k <= 20; k++)
      begin
        r32 = rnd();
        op_addr = r32[7:0];
        op_bit = r32[10:8];
        op_imm = r32[31:24];
        // all ones then all zeros force each skip both ways
        mem_rdata = (rd == 0) ? 8'hFF : (rd == 1) ? 8'h00 : r32[23:16];
        if (rd % 5 == 4 && k == 10)
          wr_ptr(r32[11], r32[19:12]);
        if (rd < 2)
          run_op(ssx_op_t'(k));
        else
          run_op(ssx_op_t'(5'(1 + rnd() % 20)));
      end
    end
    results();
  end

endmodule
